// ===== inc/ifp_consts.svh
// Named constants for the interrupt force and pending block
`ifndef IFP_CONSTS_SVH
`define IFP_CONSTS_SVH
// ==========================================================
// Widths
`define IFP_NSRC 11
`define IFP_FLD_W 16
`define IFP_DATA_W 32
`define IFP_EV_W 3
// ==========================================================
// Register byte addresses
`define IFP_ADDR_FORCE 32'h8002_0034
`define IFP_ADDR_NPEND 32'h8002_0038
`define IFP_ADDR_FPEND 32'h8002_003c
`define IFP_ADDR_EVSTAT 32'h8002_0040
`define IFP_ADDR_EVCLR 32'h8002_0044
`define IFP_ADDR_EVEN 32'h8002_0048
// ==========================================================
// Reset values
`define IFP_RST_FORCE 16'h0000
`define IFP_RST_PEND 11'h000
`define IFP_RST_EV 3'h0
`define IFP_RST_DATA 32'h0000_0000
// ==========================================================
// Event bit positions
`define IFP_EV_NPEND 0
`define IFP_EV_FPEND 1
`define IFP_EV_NARROW 2
// ==========================================================
// Bus codes
`define IFP_STRB_FULL 4'hf
`define IFP_RESP_OKAY 2'h0
`define IFP_RESP_SLVERR 2'h2
`endif

// ===== inc/ifp_pkg.sv
// Types shared by the interrupt force and pending block
`include "ifp_consts.svh"
package ifp_pkg;
	// ==========================================================
	// Per-source and event vectors
	typedef logic [`IFP_NSRC-1:0] ifp_vec_t;
	typedef logic [`IFP_EV_W-1:0] ifp_ev_t;
	// Source inputs from the enable, class and request logic
	typedef struct packed {
		ifp_vec_t source_enable_bits;
		ifp_vec_t source_class_select;
		ifp_vec_t raw_request_bits;
	} ifp_src_s;
	// Pending lines to the processor core
	typedef struct packed {
		ifp_vec_t normal_pending_bits;
		ifp_vec_t fast_pending_bits;
	} ifp_pend_s;
endpackage : ifp_pkg

// ===== rtl/ifp_top.sv
// Interrupt force register and normal/fast pending logic with AXI4-Lite slave
`timescale 1ns/1ps
`include "ifp_consts.svh"

module ifp_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [31:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire ifp_pkg::ifp_src_s src_in,
	output ifp_pkg::ifp_pend_s pend_out,
	output logic evt_irq
);

	// ==========================================================
	// Write channel state
	logic aw_hold_q;
	logic w_hold_q;
	logic [31:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic [1:0] bresp_d;

	// Read channel state
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	// Block state
	logic [`IFP_FLD_W-1:0] force_q;
	ifp_pkg::ifp_vec_t npend_q;
	ifp_pkg::ifp_vec_t fpend_q;
	ifp_pkg::ifp_vec_t npend_d;
	ifp_pkg::ifp_vec_t fpend_d;
	ifp_pkg::ifp_vec_t req_eff;
	ifp_pkg::ifp_ev_t ev_stat_q;
	ifp_pkg::ifp_ev_t ev_stat_d;
	ifp_pkg::ifp_ev_t ev_en_q;
	ifp_pkg::ifp_ev_t ev_set;
	ifp_pkg::ifp_ev_t ev_clr;

	// ==========================================================
	// Write handshakes; the address and data may arrive in either order
	assign awready = !aw_hold_q && !bvalid_q;
	assign wready = !w_hold_q && !bvalid_q;
	wire aw_take = awvalid && awready;
	wire w_take = wvalid && wready;
	wire wr_go = aw_hold_q && w_hold_q && !bvalid_q;

	// Write address decode on the held address
	wire wr_force = awaddr_q == `IFP_ADDR_FORCE;
	wire wr_np = awaddr_q == `IFP_ADDR_NPEND;
	wire wr_fp = awaddr_q == `IFP_ADDR_FPEND;
	wire wr_evs = awaddr_q == `IFP_ADDR_EVSTAT;
	wire wr_evc = awaddr_q == `IFP_ADDR_EVCLR;
	wire wr_eve = awaddr_q == `IFP_ADDR_EVEN;
	wire wr_known = wr_force || wr_np || wr_fp || wr_evs || wr_evc || wr_eve;
	wire wr_full = wstrb_q == `IFP_STRB_FULL;

	// Partial stores to the force word are dropped so no half-word can tear it
	wire force_we = wr_go && wr_force && wr_full;
	wire narrow_wr = wr_go && wr_force && !wr_full;
	wire eve_we = wr_go && wr_eve;
	wire evc_we = wr_go && wr_evc;

	// Pending and status words are read-only; writes to them are ignored
	assign bresp_d = (!wr_known || narrow_wr) ? `IFP_RESP_SLVERR : `IFP_RESP_OKAY;

	// Holding registers for the write address and data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= `IFP_RST_DATA;
			wdata_q <= `IFP_RST_DATA;
			wstrb_q <= 4'h0;
		end else begin
			aw_hold_q <= aw_take || (aw_hold_q && !wr_go);
			w_hold_q <= w_take || (w_hold_q && !wr_go);
			if (aw_take) begin
				awaddr_q <= awaddr;
			end
			if (w_take) begin
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end
		end
	end

	// Write response stands until the master takes it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= `IFP_RESP_OKAY;
		end else if (wr_go) begin
			bvalid_q <= 1'b1;
			bresp_q <= bresp_d;
		end else if (bready) begin
			bvalid_q <= 1'b0;
		end
	end

	assign bvalid = bvalid_q;
	assign bresp = bresp_q;

	// ==========================================================
	// Software force register; bits 15-11 store but drive nothing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			force_q <= `IFP_RST_FORCE;
		end else if (force_we) begin
			force_q <= wdata_q[`IFP_FLD_W-1:0];
		end
	end

	// ==========================================================
	// Effective request: hardware line OR software force, valid bits only
	assign req_eff = src_in.raw_request_bits | force_q[`IFP_NSRC-1:0];

	// Class selection steers each enabled source to exactly one pending vector
	assign npend_d = src_in.source_enable_bits & ~src_in.source_class_select
		& req_eff;
	assign fpend_d = src_in.source_enable_bits & src_in.source_class_select
		& req_eff;

	// Pending registers give the core glitch-free lines one cycle behind inputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			npend_q <= `IFP_RST_PEND;
			fpend_q <= `IFP_RST_PEND;
		end else begin
			npend_q <= npend_d;
			fpend_q <= fpend_d;
		end
	end

	assign pend_out.normal_pending_bits = npend_q;
	assign pend_out.fast_pending_bits = fpend_q;

	// ==========================================================
	// Events: a new normal or fast request, and a refused partial force store
	assign ev_set[`IFP_EV_NPEND] = |(npend_d & ~npend_q);
	assign ev_set[`IFP_EV_FPEND] = |(fpend_d & ~fpend_q);
	assign ev_set[`IFP_EV_NARROW] = narrow_wr;
	assign ev_clr = evc_we ? wdata_q[`IFP_EV_W-1:0] : `IFP_RST_EV;

	// A set in the clearing cycle wins so no event is lost
	assign ev_stat_d = (ev_stat_q & ~ev_clr) | ev_set;

	// Sticky status and enable registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ev_stat_q <= `IFP_RST_EV;
			ev_en_q <= `IFP_RST_EV;
		end else begin
			ev_stat_q <= ev_stat_d;
			if (eve_we) begin
				ev_en_q <= wdata_q[`IFP_EV_W-1:0];
			end
		end
	end

	// Level interrupt, high while an enabled status bit is set
	assign evt_irq = |(ev_stat_q & ev_en_q);

	// ==========================================================
	// Read decode and zero-extended read values; upper bits read zero
	assign arready = !rvalid_q;
	wire ar_take = arvalid && arready;
	wire rd_force = araddr == `IFP_ADDR_FORCE;
	wire rd_np = araddr == `IFP_ADDR_NPEND;
	wire rd_fp = araddr == `IFP_ADDR_FPEND;
	wire rd_evs = araddr == `IFP_ADDR_EVSTAT;
	wire rd_evc = araddr == `IFP_ADDR_EVCLR;
	wire rd_eve = araddr == `IFP_ADDR_EVEN;
	wire rd_known = rd_force || rd_np || rd_fp || rd_evs || rd_evc || rd_eve;
	wire [31:0] v_force = {{(`IFP_DATA_W-`IFP_FLD_W){1'b0}}, force_q};
	wire [31:0] v_np = {{(`IFP_DATA_W-`IFP_NSRC){1'b0}}, npend_q};
	wire [31:0] v_fp = {{(`IFP_DATA_W-`IFP_NSRC){1'b0}}, fpend_q};
	wire [31:0] v_evs = {{(`IFP_DATA_W-`IFP_EV_W){1'b0}}, ev_stat_q};
	wire [31:0] v_eve = {{(`IFP_DATA_W-`IFP_EV_W){1'b0}}, ev_en_q};
	wire [31:0] rd_val = rd_force ? v_force :
		rd_np ? v_np :
		rd_fp ? v_fp :
		rd_evs ? v_evs :
		rd_eve ? v_eve : `IFP_RST_DATA;

	// Read data is captured at the address handshake and held until taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= `IFP_RST_DATA;
			rresp_q <= `IFP_RESP_OKAY;
		end else if (ar_take) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_val;
			rresp_q <= rd_known ? `IFP_RESP_OKAY : `IFP_RESP_SLVERR;
		end else if (rready) begin
			rvalid_q <= 1'b0;
		end
	end

	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;

	// ==========================================================
	// Checks
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Helper: sources that force alone should make pending
	wire [`IFP_NSRC-1:0] f_norm = src_in.source_enable_bits
		& ~src_in.source_class_select & force_q[`IFP_NSRC-1:0];
	wire [`IFP_NSRC-1:0] f_fast = src_in.source_enable_bits
		& src_in.source_class_select & force_q[`IFP_NSRC-1:0];
	wire [`IFP_NSRC-1:0] en_norm = src_in.source_enable_bits
		& ~src_in.source_class_select;
	wire [`IFP_NSRC-1:0] en_fast = src_in.source_enable_bits
		& src_in.source_class_select;
	wire rd_pend = ar_take && (rd_np || rd_fp);

	a_force_raises_pend: assert property (
		1'b1 |=> ((npend_q & $past(f_norm)) == $past(f_norm))
			&& ((fpend_q & $past(f_fast)) == $past(f_fast)))
		else $error("Forced source did not become pending");

	a_force_word_store: assert property (
		force_we |=> force_q == $past(wdata_q[`IFP_FLD_W-1:0]) ##1
			(npend_q & $past(f_norm)) == $past(f_norm))
		else $error("Force store not kept or not acted on");

	a_force_clear_std: assert property (
		force_q == `IFP_RST_FORCE |=>
			npend_q == $past(en_norm & src_in.raw_request_bits))
		else $error("Pending differs from hardware request with force clear");

	a_narrow_dropped: assert property (
		narrow_wr |=> $stable(force_q) && bvalid_q && bresp_q == `IFP_RESP_SLVERR)
		else $error("Partial force store was not refused");

	a_upper_read_zero: assert property (
		rd_pend |=> rdata_q[`IFP_DATA_W-1:`IFP_NSRC] == 21'h000000)
		else $error("Pending read shows bits above the valid sources");

	a_inputs_drive_pend: assert property (
		$stable(src_in) && $stable(force_q) |=> $stable(pend_out))
		else $error("Pending changed without a change of its inputs");

	a_normal_needs_cond: assert property (
		1'b1 |=> (npend_q & ~$past(en_norm & req_eff)) == `IFP_RST_PEND)
		else $error("Normal pending without enable, class or request");

	a_reset_pend_zero: assert property (
		$rose(aresetn) |-> npend_q == `IFP_RST_PEND && fpend_q == `IFP_RST_PEND)
		else $error("Pending not zero after reset");

	a_fast_needs_cond: assert property (
		1'b1 |=> (fpend_q & ~$past(en_fast & req_eff)) == `IFP_RST_PEND)
		else $error("Fast pending without enable, class or request");

	a_fast_ro: assert property (
		wr_go && wr_fp ##1 $stable(src_in) && $stable(force_q) |=> $stable(fpend_q))
		else $error("Write disturbed the fast pending register");

	a_idle_no_pend: assert property (
		src_in.raw_request_bits == `IFP_RST_PEND && force_q == `IFP_RST_FORCE
			|=> npend_q == `IFP_RST_PEND && fpend_q == `IFP_RST_PEND)
		else $error("Pending without any request");

	a_one_class_only: assert property (
		(npend_q & fpend_q) == `IFP_RST_PEND)
		else $error("Source pending in both classes");

	// Checked every cycle on the normal pending event bit only: a new normal request, or a set bit not being cleared, keeps it set
	a_event_sticky: assert property (
		ev_set[`IFP_EV_NPEND] || (ev_stat_q[`IFP_EV_NPEND] && !ev_clr[`IFP_EV_NPEND])
			|=> ev_stat_q[`IFP_EV_NPEND])
		else $error("Event bit not sticky");

	// Main scenarios
	c_force_store: cover property (force_we ##2 npend_q != `IFP_RST_PEND);
	c_narrow_store: cover property (narrow_wr);
	c_both_classes: cover property (npend_q != `IFP_RST_PEND && fpend_q != `IFP_RST_PEND);
	c_irq_raised: cover property ($rose(evt_irq));

endmodule : ifp_top

// ===== dv/ifp_core_model.sv
// Behavioural processor core that takes the normal and fast request lines
`timescale 1ns/1ps
module ifp_core_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire ifp_pkg::ifp_pend_s pend_in,
	output logic nirq_q,
	output logic firq_q
);
	// ==========================================================
	// Core model
	// Any pending line of a class is one request of that class at the core
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nirq_q <= 1'b0;
			firq_q <= 1'b0;
		end else begin
			nirq_q <= |pend_in.normal_pending_bits;
			firq_q <= |pend_in.fast_pending_bits;
		end
	end
endmodule : ifp_core_model

// ===== dv/tb_irq_force_and_pending_logic.sv
// Self-checking bench for the force register and the pending logic
`timescale 1ns/1ps
`include "ifp_consts.svh"
module tb_irq_force_and_pending_logic;
	// ==========================================================
	// Signals
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, d;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, evt_irq, nirq, firq;
	logic [1:0] bresp, rresp, r;
	logic [10:0] nx, fx;
	ifp_pkg::ifp_src_s src = 33'h0;
	ifp_pkg::ifp_pend_s pend;
	int mismatches = 0;
	int checks = 0;
	// Enable, class, raw and force per case; the last one leaves every source idle
	logic [10:0] en_t [6] = '{11'h7ff, 11'h7ff, 11'h555, 11'h7ff, 11'h000, 11'h7ff};
	logic [10:0] cl_t [6] = '{11'h000, 11'h7ff, 11'h0f0, 11'h2aa, 11'h000, 11'h0f0};
	logic [10:0] rw_t [6] = '{11'h7ff, 11'h7ff, 11'h3cc, 11'h000, 11'h7ff, 11'h000};
	logic [10:0] fr_t [6] = '{11'h000, 11'h000, 11'h000, 11'h7ff, 11'h000, 11'h000};

	always #12.5 aclk = ~aclk;

	// ==========================================================
	// Design and core model; protection bits are not used by the block
	ifp_top ifp_top_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .src_in(src), .pend_out(pend), .evt_irq(evt_irq));
	ifp_core_model ifp_core_model_i (.aclk(aclk), .aresetn(aresetn), .pend_in(pend),
		.nirq_q(nirq), .firq_q(firq));

	// ==========================================================
	// Check and bus tasks; wr and rd each start one edge late so no strobe is set twice in a step
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [3:0] s);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [31:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd

	task automatic summarize();
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : summarize

	// ==========================================================
	// Watchdog; the whole sequence needs well under a thousand cycles
	initial begin
		repeat (3000) @(posedge aclk);
		mismatches++;
		summarize();
	end

	// ==========================================================
	// Test sequence
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`IFP_ADDR_FORCE);
		chk(d, 32'h0);
		chk(pend, 32'h0);
		rd(`IFP_ADDR_NPEND);
		chk(d, 32'h0);
		rd(`IFP_ADDR_FPEND);
		chk(d, 32'h0);
		// Unused force bits are set too: they must store but never raise a request
		for (int i = 0; i < 6; i++) begin
			wr(`IFP_ADDR_FORCE, {16'hffff, 5'h1f, fr_t[i]}, `IFP_STRB_FULL);
			src <= {en_t[i], cl_t[i], rw_t[i]};
			// A store to the fast pending word must not disturb what follows
			wr(`IFP_ADDR_FPEND, 32'hffff_ffff, `IFP_STRB_FULL);
			chk(r, `IFP_RESP_OKAY);
			rd(`IFP_ADDR_FORCE);
			chk(d, {16'h0, 5'h1f, fr_t[i]});
			nx = en_t[i] & ~cl_t[i] & (rw_t[i] | fr_t[i]);
			fx = en_t[i] & cl_t[i] & (rw_t[i] | fr_t[i]);
			chk(pend, {10'h0, nx, fx});
			rd(`IFP_ADDR_NPEND);
			chk(d, {21'h0, nx});
			rd(`IFP_ADDR_FPEND);
			chk(d, {21'h0, fx});
			chk({nirq, firq}, {|nx, |fx});
		end
		// A narrow store to the force register is refused and leaves it alone
		wr(`IFP_ADDR_FORCE, 32'h0000_0001, 4'h3);
		chk(r, `IFP_RESP_SLVERR);
		rd(`IFP_ADDR_FORCE);
		chk(d, 32'h0000_f800);
		rd(`IFP_ADDR_EVSTAT);
		chk(d, 32'h7);
		wr(`IFP_ADDR_NPEND, 32'hffff_ffff, `IFP_STRB_FULL);
		chk(r, `IFP_RESP_OKAY);
		rd(`IFP_ADDR_NPEND);
		chk(d, 32'h0);
		wr(32'h8002_0050, 32'h1, `IFP_STRB_FULL);
		chk(r, `IFP_RESP_SLVERR);
		rd(32'h8002_0050);
		chk(r, `IFP_RESP_SLVERR);
		chk(d, 32'h0);
		// Event interrupt: raise by a forced request, then mask and clear
		wr(`IFP_ADDR_EVCLR, 32'h7, `IFP_STRB_FULL);
		wr(`IFP_ADDR_EVEN, 32'h1, `IFP_STRB_FULL);
		src <= {11'h7ff, 11'h000, 11'h000};
		wr(`IFP_ADDR_FORCE, 32'h1, `IFP_STRB_FULL);
		repeat (2) @(posedge aclk);
		#1;
		chk(evt_irq, 1'b1);
		wr(`IFP_ADDR_EVEN, 32'h0, `IFP_STRB_FULL);
		#1;
		chk(evt_irq, 1'b0);
		wr(`IFP_ADDR_EVCLR, 32'h1, `IFP_STRB_FULL);
		wr(`IFP_ADDR_EVEN, 32'h1, `IFP_STRB_FULL);
		#1;
		chk(evt_irq, 1'b0);
		wr(`IFP_ADDR_EVSTAT, 32'h7, `IFP_STRB_FULL);
		chk(r, `IFP_RESP_OKAY);
		rd(`IFP_ADDR_EVSTAT);
		chk(d, 32'h0);
		rd(`IFP_ADDR_EVCLR);
		chk(d, 32'h0);
		rd(`IFP_ADDR_EVEN);
		chk(d, 32'h1);
		summarize();
	end
endmodule : tb_irq_force_and_pending_logic
